// ==== power_good_fault_latch.sv ====
// power good sequencing, fault latch and over-temperature response
//
// Overview of operation
// RULE1: trip over-temperature when junction exceeds threshold
// RULE2: fault response is hiccup or latch-off, configurable
// RULE3: latch-off cleared only by enable or bias cycle
// RULE4: power good pin only pulls low or releases
// RULE5: compensation control bit zero selects bidirectional mode
// RULE6: single phase should use output-only mode
// RULE7: multi-phase uses bidirectional to see slave faults
// RULE8: power good low from power-up
// RULE9: release after good threshold and programmed delay
// RULE10: any protection forces and latches power good low
// RULE11: latched low until a new soft start
// RULE12: input supply failure latches power good low
// RULE13: under-voltage trips, then hiccup or latch-off
// RULE14: external low in bidirectional mode is peer fault
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module power_good_fault_latch
  import pwr_ok_pkg::*;
#(
  parameter int HICCUP_CYCLES = HICCUP_US * CLOCK_MHZ
)(
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // control and sense
  input wire logic enable_in,
  input wire logic soft_start_done_in,
  input wire sense_s sense_in,
  // shared power good line
  input wire logic pwr_ok_signal_in,
  output logic pwr_ok_signal_out,
  output logic pwr_ok_signal_oe_out,
  // converter control
  output logic switching_en_out,
  output logic soft_start_out,
  output logic latched_off_out,
  // register bus
  input wire bus_req_s bus_in,
  output logic [31:0] rdata_out,
  output logic irq_out
);

  typedef struct packed {
    seq_e st;
    logic [7:0] comp_ctrl;
    logic [15:0] out_ctrl;
    logic [11:0] ot_thresh;
    logic [11:0] uv_thresh;
    logic [11:0] good_thresh;
    logic [2:0] resp;
    logic [IRQ_WIDTH-1:0] irq_stat;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [2:0] pin_sync;
    logic [2:0] en_sync;
    logic pin_low;
    logic en_lvl;
    logic latched;
    logic [31:0] timer;
    logic [15:0] delay_cnt;
    logic [31:0] rdata;
    logic drive_low;
    logic irq;
    logic [2:0] rel_cnt;
    logic sw_en;
    logic ss_on;
  } state_s;

  state_s q, d;

  // takes the new value once the second and third sync stages agree on it
  function automatic logic filt(input logic [2:0] s, input logic old);
    filt = (s[2] == s[1]) ? s[1] : old;
  endfunction : filt

  // write hit decode
  function automatic logic hit(input bus_req_s b, input logic [9:0] a);
    hit = b.wr && (b.addr == a);
  endfunction : hit

  logic ot_trip, uv_trip, ov_trip, lock_trip, peer_trip, any_fault;
  logic latch_resp;
  logic [IRQ_WIDTH-1:0] ev;

  // next state of the whole block
  always_comb
  begin
    d = q;
    d.pin_sync = {q.pin_sync[1:0], pwr_ok_signal_in};
    d.en_sync = {q.en_sync[1:0], enable_in};
    d.pin_low = ~filt(q.pin_sync, ~q.pin_low);
    d.en_lvl = filt(q.en_sync, q.en_lvl);
    ev = '0;
    // fault detection; under-voltage and peer trips only in the good state
    ot_trip = (sense_in.temp > q.ot_thresh); // see RULE1
    uv_trip = (q.st == ST_GOOD) &&
      (sense_in.feedback < q.uv_thresh); // see RULE13
    ov_trip = sense_in.ov;
    lock_trip = sense_in.lockout; // see RULE12
    // count cycles since release so the sync chain catches up
    if (q.drive_low)
    begin
      d.rel_cnt = '0;
    end
    else if (q.rel_cnt != PEER_SETTLE_CYCLES)
    begin
      d.rel_cnt = q.rel_cnt + 3'h1;
    end
    // peer pulls line low while we release it
    peer_trip = q.comp_ctrl[PWR_OK_BIDIR_BIT] && q.pin_low &&
      !q.drive_low && (q.st == ST_GOOD) &&
      (q.rel_cnt == PEER_SETTLE_CYCLES); // see RULE14 RULE7
    any_fault = ot_trip || uv_trip || ov_trip || lock_trip || peer_trip;
    latch_resp = (ot_trip && q.resp[RESP_OT_LATCH_BIT]) ||
      (uv_trip && q.resp[RESP_UV_LATCH_BIT]) ||
      (ov_trip && q.resp[RESP_OV_LATCH_BIT]); // see RULE2
    // sequencer
    unique case (q.st)
      ST_OFF:
      begin
        if (q.en_lvl && !q.latched && !lock_trip)
        begin
          d.st = ST_START;
        end
      end
      ST_START:
      begin
        if (any_fault)
        begin
          d.st = ST_FAULT;
        end
        else if (soft_start_done_in &&
          sense_in.feedback >= q.good_thresh)
        begin
          d.st = ST_DELAY;
          d.delay_cnt = q.out_ctrl;
          d.timer = '0;
        end
      end
      ST_DELAY:
      begin
        if (any_fault)
        begin
          d.st = ST_FAULT;
        end
        else if (q.delay_cnt == 16'h0000)
        begin
          d.st = ST_GOOD; // see RULE9
          ev[IRQ_GOOD_BIT] = 1'b1;
        end
        else if (q.timer == 32'(TICK_CYCLES - 1))
        begin
          d.timer = '0;
          d.delay_cnt = q.delay_cnt - 16'h0001;
        end
        else
        begin
          d.timer = q.timer + 32'h0000_0001;
        end
      end
      ST_GOOD:
      begin
        if (any_fault)
        begin
          d.st = ST_FAULT;
        end
      end
      ST_FAULT:
      begin
        // hiccup waits then restarts; latch waits for enable cycle
        if (q.latched)
        begin
          d.st = ST_OFF;
        end
        else if (q.timer >= 32'(HICCUP_CYCLES - 1))
        begin
          d.timer = '0;
          d.st = ST_OFF;
        end
        else
        begin
          d.timer = q.timer + 32'h0000_0001;
        end
      end
      default:
      begin
        d.st = ST_OFF;
      end
    endcase
    // entry into fault from a running state
    if ((q.st != ST_FAULT) && (q.st != ST_OFF) && any_fault)
    begin
      d.timer = '0;
      if (latch_resp)
      begin
        d.latched = 1'b1;
      end
      ev[IRQ_OT_BIT] = ot_trip;
      ev[IRQ_UV_BIT] = uv_trip;
      ev[IRQ_OV_BIT] = ov_trip;
      ev[IRQ_LOCKOUT_BIT] = lock_trip;
      ev[IRQ_PEER_BIT] = peer_trip;
    end
    // losing enable clears the latch and stops the converter
    if (!q.en_lvl)
    begin
      d.latched = 1'b0; // see RULE3
      d.st = ST_OFF;
    end
    // low at power-up and latched low until a new soft start
    d.drive_low = (d.st != ST_GOOD); // see RULE8 RULE10 RULE11
    // converter controls registered from the next state
    d.sw_en = (d.st == ST_START) || (d.st == ST_DELAY) ||
      (d.st == ST_GOOD);
    d.ss_on = (d.st == ST_START);
    // register writes
    if (hit(bus_in, COMPENSATION_CONTROL_ADDR))
    begin
      d.comp_ctrl = bus_in.wdata[7:0]; // see RULE5
    end
    if (hit(bus_in, OUTPUT_CONTROL_ADDR))
    begin
      d.out_ctrl = bus_in.wdata[15:0];
    end
    if (hit(bus_in, OVERTEMP_THRESHOLD_ADDR))
    begin
      d.ot_thresh = bus_in.wdata[11:0];
    end
    if (hit(bus_in, UNDERVOLT_THRESHOLD_ADDR))
    begin
      d.uv_thresh = bus_in.wdata[11:0];
    end
    if (hit(bus_in, GOOD_THRESHOLD_ADDR))
    begin
      d.good_thresh = bus_in.wdata[11:0];
    end
    if (hit(bus_in, FAULT_RESPONSE_ADDR))
    begin
      d.resp = bus_in.wdata[2:0];
    end
    if (hit(bus_in, IRQ_MASK_ADDR))
    begin
      d.irq_mask = bus_in.wdata[IRQ_WIDTH-1:0];
    end
    // sticky status: set wins over write-one clear
    d.irq_stat = q.irq_stat;
    if (hit(bus_in, IRQ_STATUS_ADDR))
    begin
      d.irq_stat = q.irq_stat & ~bus_in.wdata[IRQ_WIDTH-1:0];
    end
    d.irq_stat = d.irq_stat | ev;
    d.irq = |(d.irq_stat & d.irq_mask);
    // read data, valid the cycle after the strobe
    d.rdata = '0;
    if (bus_in.rd)
    begin
      unique case (bus_in.addr)
        COMPENSATION_CONTROL_ADDR: d.rdata = {24'h0000_00, q.comp_ctrl};
        OUTPUT_CONTROL_ADDR: d.rdata = {16'h0000, q.out_ctrl};
        OVERTEMP_THRESHOLD_ADDR: d.rdata = {20'h0_0000, q.ot_thresh};
        UNDERVOLT_THRESHOLD_ADDR: d.rdata = {20'h0_0000, q.uv_thresh};
        GOOD_THRESHOLD_ADDR: d.rdata = {20'h0_0000, q.good_thresh};
        FAULT_RESPONSE_ADDR: d.rdata = {29'h0000_0000, q.resp};
        STATUS_ADDR: d.rdata = {24'h0000_00, q.pin_low, q.latched,
          1'b0, q.st};
        IRQ_STATUS_ADDR: d.rdata = {26'h000_0000, q.irq_stat};
        IRQ_MASK_ADDR: d.rdata = {26'h000_0000, q.irq_mask};
        default: d.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      q <= '{st: ST_OFF, comp_ctrl: COMP_CTRL_RESET,
        out_ctrl: OUT_CTRL_RESET, ot_thresh: OT_THRESH_RESET,
        uv_thresh: UV_THRESH_RESET, good_thresh: GOOD_THRESH_RESET,
        resp: RESP_RESET, pin_sync: 3'h7, pin_low: 1'b0,
        drive_low: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // outputs: open drain, only low or released
  assign pwr_ok_signal_out = 1'b0; // see RULE4
  assign pwr_ok_signal_oe_out = q.drive_low;
  assign switching_en_out = q.sw_en;
  assign soft_start_out = q.ss_on;
  assign latched_off_out = q.latched;
  assign rdata_out = q.rdata;
  assign irq_out = q.irq;

endmodule : power_good_fault_latch

// ==== pwr_ok_pkg.sv ====
// constants, register map and types for the power good fault latch
package pwr_ok_pkg;

  // register indices (byte address is four times the index)
  localparam logic [7:0] COMPENSATION_CONTROL_IDX = 8'hd0;
  localparam logic [7:0] OUTPUT_CONTROL_IDX = 8'hd1;
  localparam logic [7:0] OVERTEMP_THRESHOLD_IDX = 8'h4f;
  localparam logic [7:0] UNDERVOLT_THRESHOLD_IDX = 8'h44;
  localparam logic [7:0] GOOD_THRESHOLD_IDX = 8'h5e;
  localparam logic [7:0] FAULT_RESPONSE_IDX = 8'he0;
  localparam logic [7:0] STATUS_IDX = 8'he1;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'he2;
  localparam logic [7:0] IRQ_MASK_IDX = 8'he3;
  localparam logic [9:0] COMPENSATION_CONTROL_ADDR = 10'h340;
  localparam logic [9:0] OUTPUT_CONTROL_ADDR = 10'h344;
  localparam logic [9:0] OVERTEMP_THRESHOLD_ADDR = 10'h13c;
  localparam logic [9:0] UNDERVOLT_THRESHOLD_ADDR = 10'h110;
  localparam logic [9:0] GOOD_THRESHOLD_ADDR = 10'h178;
  localparam logic [9:0] FAULT_RESPONSE_ADDR = 10'h380;
  localparam logic [9:0] STATUS_ADDR = 10'h384;
  localparam logic [9:0] IRQ_STATUS_ADDR = 10'h388;
  localparam logic [9:0] IRQ_MASK_ADDR = 10'h38c;

  // field positions
  localparam int PWR_OK_BIDIR_BIT = 0;
  localparam int RESP_OT_LATCH_BIT = 0;
  localparam int RESP_UV_LATCH_BIT = 1;
  localparam int RESP_OV_LATCH_BIT = 2;
  localparam int IRQ_OT_BIT = 0;
  localparam int IRQ_UV_BIT = 1;
  localparam int IRQ_OV_BIT = 2;
  localparam int IRQ_LOCKOUT_BIT = 3;
  localparam int IRQ_PEER_BIT = 4;
  localparam int IRQ_GOOD_BIT = 5;
  localparam int IRQ_WIDTH = 6;

  // reset values
  localparam logic [7:0] COMP_CTRL_RESET = 8'h00;
  localparam logic [15:0] OUT_CTRL_RESET = 16'h0010;
  localparam logic [11:0] OT_THRESH_RESET = 12'h0_7d0;
  localparam logic [11:0] UV_THRESH_RESET = 12'h0_200;
  localparam logic [11:0] GOOD_THRESH_RESET = 12'h0_250;
  localparam logic [2:0] RESP_RESET = 3'h0;

  // timing: good delay counts in microsecond ticks, hiccup off time
  localparam int CLOCK_MHZ = 125;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS * CLOCK_MHZ) / 1000;
  localparam int HICCUP_US = 10000;
  // cycles after release before the synced line is trusted
  localparam logic [2:0] PEER_SETTLE_CYCLES = 3'h4;

  // sequencer states
  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_START = 5'b00010,
    ST_DELAY = 5'b00100,
    ST_GOOD = 5'b01000,
    ST_FAULT = 5'b10000
  } seq_e;

  // analog sense samples
  typedef struct packed {
    logic [11:0] temp;
    logic [11:0] feedback;
    logic ov;
    logic lockout;
  } sense_s;

  // register bus request
  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

endpackage : pwr_ok_pkg

// ==== pwr_ok_chk.sv ====
// port assertions for the power good fault latch
`timescale 1ns/10ps
module pwr_ok_chk
  import pwr_ok_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire sense_s sense_in,
  input wire logic pwr_ok_signal_out,
  input wire logic pwr_ok_signal_oe_out,
  input wire logic switching_en_out,
  input wire logic soft_start_out,
  input wire logic latched_off_out
);
  // one clock domain, reset disables all checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  wire logic oe = pwr_ok_signal_oe_out;

  // open drain data and start-up hold
  property p_open_drain;
    !pwr_ok_signal_out;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("power good data not low");
  property p_start_low;
    $rose(switching_en_out) |-> oe && soft_start_out;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start without line held low");
  // release only after delay, from the delay phase
  property p_release_delay;
    $fell(oe) |-> $past(oe, 100);
  endproperty
  a_release_delay: assert property (p_release_delay)
    else $error("release came too early");
  property p_release_path;
    $fell(oe) |-> $past(switching_en_out) && !$past(soft_start_out);
  endproperty
  a_release_path: assert property (p_release_path)
    else $error("release outside a fresh start");
  // faults while good pull the line within three cycles
  property p_trip_ot;
    !oe && sense_in.temp > OT_THRESH_RESET |-> ##[1:3] oe;
  endproperty
  a_trip_ot: assert property (p_trip_ot)
    else $error("over-temperature did not pull line");
  property p_trip_uv;
    !oe && sense_in.feedback < UV_THRESH_RESET |-> ##[1:3] oe;
  endproperty
  a_trip_uv: assert property (p_trip_uv)
    else $error("under-voltage did not pull line");
  property p_trip_ov;
    !oe && sense_in.ov |-> ##[1:3] oe;
  endproperty
  a_trip_ov: assert property (p_trip_ov)
    else $error("over-voltage did not pull line");
  property p_trip_lockout;
    !oe && sense_in.lockout |-> ##[1:3] oe;
  endproperty
  a_trip_lockout: assert property (p_trip_lockout)
    else $error("input lockout did not pull line");
  property p_latched;
    latched_off_out |-> oe && !switching_en_out;
  endproperty
  a_latched: assert property (p_latched)
    else $error("latched off but running");
endmodule : pwr_ok_chk

// ==== pwr_ok_partner.sv ====
// supervisor pull-up and peer phase on the shared line
`timescale 1ns/10ps
module pwr_ok_partner (
  input wire logic oe_in,
  input wire logic peer_pull_in,
  output logic line_out
);
  // wired low with pull-up, released line reads high
  assign line_out = !(oe_in || peer_pull_in);
endmodule : pwr_ok_partner

// ==== power_good_fault_latch_tb.sv ====
// testbench for the power good fault latch
`timescale 1ns/10ps
module power_good_fault_latch_tb;
  import pwr_ok_pkg::*;
  localparam sense_s sense_ok = '{12'h0_100, 12'h0_300, 1'b0, 1'b0};
  logic clock_in, rst_in, enable_in, ss_done, line, peer_pull;
  logic oe, od, sw, ss, latched, irq;
  sense_s sense;
  bus_req_s bus;
  logic [31:0] rdata;
  int failures = 0;
  int samples_checked = 0;

  power_good_fault_latch #(.HICCUP_CYCLES(50)) uut (.clock_in(clock_in),
    .rst_in(rst_in), .enable_in(enable_in), .soft_start_done_in(ss_done),
    .sense_in(sense), .pwr_ok_signal_in(line), .pwr_ok_signal_out(od),
    .pwr_ok_signal_oe_out(oe), .switching_en_out(sw), .soft_start_out(ss),
    .latched_off_out(latched), .bus_in(bus), .rdata_out(rdata),
    .irq_out(irq));
  pwr_ok_partner peer (.oe_in(oe), .peer_pull_in(peer_pull), .line_out(line));

  // clock
  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clock_in);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_in);
    bus <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clock_in);
    bus <= '{a, 32'h0000, 1'b0, 1'b1};
    @(posedge clock_in);
    bus <= '0;
    #1 chk(rdata, e);
  endtask : rd

  task automatic power_up();
    int n;
    n = 0;
    enable_in <= 1'b1;
    while (oe !== 1'b0 && n < 3000)
    begin
      @(posedge clock_in);
      n++;
    end
    chk(n >= 125, 1);
    chk(line, 1);
    chk({od, sw, ss}, 3'b010);
  endtask : power_up

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  // watchdog
  initial
  begin
    #200000;
    failures++;
    report_and_stop();
  end

  // test sequence
  initial
  begin
    rst_in = 1'b1;
    enable_in = 1'b0;
    ss_done = 1'b1;
    sense = sense_ok;
    peer_pull = 1'b0;
    bus = '0;
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    chk(oe, 1);
    rd(COMPENSATION_CONTROL_ADDR, 32'h0000_0000);
    rd(OUTPUT_CONTROL_ADDR, 32'h0000_0010);
    rd(OVERTEMP_THRESHOLD_ADDR, 32'h0000_07d0);
    rd(UNDERVOLT_THRESHOLD_ADDR, 32'h0000_0200);
    rd(GOOD_THRESHOLD_ADDR, 32'h0000_0250);
    rd(FAULT_RESPONSE_ADDR, 32'h0000_0000);
    rd(10'h3fc, 32'h0000_0000);
    $display("test reset done");
    wr(OUTPUT_CONTROL_ADDR, 32'h0000_0001);
    wr(IRQ_MASK_ADDR, 32'h0000_003f);
    for (int k = 0; k < 5; k++)
    begin
      power_up();
      if (k == 4)
      begin
        peer_pull <= 1'b1;
        repeat (8) @(posedge clock_in);
        chk(oe, 0);
        peer_pull <= 1'b0;
        repeat (8) @(posedge clock_in);
        wr(COMPENSATION_CONTROL_ADDR, 32'h0000_0001);
      end
      wr(IRQ_STATUS_ADDR, 32'h0000_003f);
      case (k)
        0: sense.temp <= 12'h7d1;
        1: sense.feedback <= 12'h1ff;
        2: sense.ov <= 1'b1;
        3: sense.lockout <= 1'b1;
        default: peer_pull <= 1'b1;
      endcase
      repeat (8) @(posedge clock_in);
      chk(oe, 1);
      chk(irq, 1);
      sense <= sense_ok;
      peer_pull <= 1'b0;
      repeat (20) @(posedge clock_in);
      chk(oe, 1);
      rd(IRQ_STATUS_ADDR, 32'h1 << k);
      wr(IRQ_MASK_ADDR, 32'h0000_0000);
      chk(irq, 0);
      wr(IRQ_MASK_ADDR, 32'h0000_003f);
      wr(IRQ_STATUS_ADDR, 32'h1 << k);
      rd(IRQ_STATUS_ADDR, 32'h0000_0000);
      chk(irq, 0);
      $display("test fault %0d done", k);
    end
    wr(FAULT_RESPONSE_ADDR, 32'h0000_0001);
    power_up();
    sense.temp <= 12'hfff;
    repeat (8) @(posedge clock_in);
    chk(latched, 1);
    sense <= sense_ok;
    repeat (100) @(posedge clock_in);
    chk({latched, oe}, 2'b11);
    rd(STATUS_ADDR, 32'h0000_00c1);
    chk({sw, ss}, 2'b00);
    enable_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    // restart below the good threshold, then with ramp unfinished
    sense.feedback <= 12'h24f;
    enable_in <= 1'b1;
    repeat (200) @(posedge clock_in);
    chk({oe, sw, ss}, 3'b111);
    sense <= sense_ok;
    ss_done <= 1'b0;
    repeat (20) @(posedge clock_in);
    chk({oe, ss}, 2'b11);
    ss_done <= 1'b1;
    power_up();
    chk(latched, 0);
    $display("test latch-off done");
    report_and_stop();
  end
endmodule : power_good_fault_latch_tb

bind power_good_fault_latch pwr_ok_chk chk (.clock_in(clock_in),
  .rst_in(rst_in), .sense_in(sense_in),
  .pwr_ok_signal_out(pwr_ok_signal_out),
  .pwr_ok_signal_oe_out(pwr_ok_signal_oe_out),
  .switching_en_out(switching_en_out), .soft_start_out(soft_start_out),
  .latched_off_out(latched_off_out));
